// >>> design/rgfc_defs.vh
// Notes on behaviour
// - 6-bit gain code, -12 to +48 dB, 1 dB
// - 3-bit gain code, -12 to +36 dB, 8 dB
// - table splits gain into coarse 6 dB, fine 1 dB
// - offset calibration at power-up and on host request
// - calibration shorts first stage, forces high gain
// - servo steps DAC until offset within +/-32 codes
// - cutoff target write starts filter calibration under 100 us
// - filter on by default, bit 0 clear bypasses
// - 8-bit cutoff target held and driven to filter
`ifndef RGFC_DEFS_VH
`define RGFC_DEFS_VH

// =============================================================
// register map
`define RGFC_ADDR_FILT_CTRL     8'h07
`define RGFC_ADDR_FILT_TARGET   8'h08
`define RGFC_ADDR_OFFS_CAL      8'h09
`define RGFC_FILT_EN_BIT        0
`define RGFC_OFFS_START_BIT     0
`define RGFC_OFFS_BUSY_BIT      1
`define RGFC_FCAL_BUSY_BIT      2
`define RGFC_FILT_CTRL_RST      8'h01
`define RGFC_FILT_TARGET_RST    8'h80

// =============================================================
// gain table
`define RGFC_GAIN_MIN_DB        12
`define RGFC_IDX6_MAX           6'h3C
`define RGFC_CODE3_MAX          3'h6
`define RGFC_COARSE_STEP        6'h06
`define RGFC_COARSE_MAX         4'h9
`define RGFC_FINE_MAX           3'h6

// =============================================================
// offset servo
`define RGFC_OFFS_WINDOW        10'sd32
`define RGFC_CAL_DAC_RST        8'h80
`define RGFC_SERVO_MAX_STEPS    8'hFF

// =============================================================
// filter calibration timing
`define RGFC_CLK_MHZ            25
`define RGFC_FCAL_TIME_US       100
// timer load value; busy lasts load + 1 cycles, kept one cycle short of
// the limit so the calibration really ends under it
`define RGFC_FCAL_CYCLES        ((`RGFC_FCAL_TIME_US * `RGFC_CLK_MHZ) - 2)

`endif

// >>> design/rgfc_gain_lut.v
`timescale 1ns/100ps
`include "rgfc_defs.vh"

// =============================================================
// gain split table: gain index (dB + 12) to coarse and fine steps
module rgfc_gain_lut
(
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire [5:0] gain_idx_i,
    output reg  [3:0] coarse_o,
    output reg  [2:0] fine_o
);

    // coarse takes whole 6 dB steps, fine takes the rest
    function [3:0] coarse_of;
        input [5:0] idx;
        reg   [5:0] quo;
        begin
            quo = idx / `RGFC_COARSE_STEP;
            if (idx >= 6'd54)
                coarse_of = `RGFC_COARSE_MAX;
            else
                coarse_of = quo[3:0];
        end
    endfunction

    wire [3:0] nxt_coarse = coarse_of(gain_idx_i);
    wire [5:0] used_db    = {2'b00, nxt_coarse} * `RGFC_COARSE_STEP;
    wire [5:0] fine_db    = gain_idx_i - used_db;  // always below 7 by construction

    // registered read data, like a small rom
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            coarse_o <= 4'h0;
            fine_o   <= 3'h0;
        end
        else
        begin
            coarse_o <= nxt_coarse;
            fine_o   <= fine_db[2:0];
        end
    end

endmodule // rgfc_gain_lut

// >>> design/rgfc_top.v
`timescale 1ns/100ps
`include "rgfc_defs.vh"

// =============================================================
// receive gain and filter control
module rgfc_top
(
    input  wire        mclk_i,
    input  wire        rst_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        gain_load_i,
    input  wire        gain_mode3_i,
    input  wire [5:0]  gain_code_i,
    input  wire        adc_valid_i,
    input  wire [9:0]  adc_offset_i,
    output wire [7:0]  reg_rdata_o,
    output wire [3:0]  coarse_gain_stage_o,
    output wire [2:0]  fine_gain_stage_o,
    output wire        input_short_o,
    output wire [7:0]  cal_dac_o,
    output wire        offset_cal_busy_o,
    output wire        filter_enable_o,
    output wire [7:0]  filter_target_o,
    output wire        filter_cal_busy_o
);

    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_SERVO = 2'b10;

    reg  [7:0]  rdata_ff;
    reg  [7:0]  filt_ctrl_ff;
    reg  [7:0]  filt_target_ff;
    reg         fcal_busy_ff;
    reg  [11:0] fcal_cnt_ff;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [7:0]  cal_dac_ff;
    reg  [7:0]  nxt_cal_dac;
    reg  [7:0]  steps_ff;
    reg  [7:0]  nxt_steps;
    reg         cal_req_ff;
    reg  [5:0]  gain_idx_ff;
    reg  [5:0]  pend_idx_ff;
    reg         pend_ff;
    reg  [3:0]  coarse_ff;
    reg  [2:0]  fine_ff;
    reg         short_ff;
    wire [3:0]  lut_coarse;
    wire [2:0]  lut_fine;
    // timer load kept as a full word, then cut to the counter width
    wire [31:0] fcal_load = `RGFC_FCAL_CYCLES;

    wire wr_ctrl   = reg_wr_i && (reg_addr_i == `RGFC_ADDR_FILT_CTRL);
    wire wr_target = reg_wr_i && (reg_addr_i == `RGFC_ADDR_FILT_TARGET);
    wire wr_offs   = reg_wr_i && (reg_addr_i == `RGFC_ADDR_OFFS_CAL);
    wire cal_on    = state_ff[1];
    wire cal_done  = cal_on && (nxt_state == ST_IDLE);

    // gain code to table index, clamped so a bad code cannot overrun
    function [5:0] gain_to_idx;
        input [5:0] code;
        input       mode3;
        begin
            if (mode3)
            begin
                if (code[2:0] > `RGFC_CODE3_MAX)
                    gain_to_idx = {`RGFC_CODE3_MAX, 3'h0};
                else
                    gain_to_idx = {code[2:0], 3'h0};
            end
            else if (code > `RGFC_IDX6_MAX)
                gain_to_idx = `RGFC_IDX6_MAX;
            else
                gain_to_idx = code;
        end
    endfunction

    // =============================================================
    // register file
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            filt_ctrl_ff   <= `RGFC_FILT_CTRL_RST;
            filt_target_ff <= `RGFC_FILT_TARGET_RST;
            rdata_ff       <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                filt_ctrl_ff <= reg_wdata_i;
            if (wr_target)
                filt_target_ff <= reg_wdata_i;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    `RGFC_ADDR_FILT_CTRL:   rdata_ff <= filt_ctrl_ff;
                    `RGFC_ADDR_FILT_TARGET: rdata_ff <= filt_target_ff;
                    `RGFC_ADDR_OFFS_CAL:    rdata_ff <= {5'h00, fcal_busy_ff, cal_on, 1'b0};
                    default:                rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    // =============================================================
    // filter calibration timer; every target write restarts it,
    // so a rewrite of the same value recalibrates for drift
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fcal_busy_ff <= 1'b0;
            fcal_cnt_ff  <= 12'h000;
        end
        else if (wr_target)
        begin
            fcal_busy_ff <= 1'b1;
            fcal_cnt_ff  <= fcal_load[11:0];
        end
        else if (fcal_busy_ff)
        begin
            if (fcal_cnt_ff == 12'h000)
                fcal_busy_ff <= 1'b0;
            else
                fcal_cnt_ff <= fcal_cnt_ff - 12'h001;
        end
    end

    // =============================================================
    // offset servo; a step cap ends a loop that cannot converge
    always @*
    begin
        nxt_state   = state_ff;
        nxt_cal_dac = cal_dac_ff;
        nxt_steps   = steps_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (cal_req_ff)
                begin
                    nxt_state = ST_SERVO;
                    nxt_steps = 8'h00;
                end
            end
            ST_SERVO:
            begin
                if (adc_valid_i)
                begin
                    if ($signed(adc_offset_i) > `RGFC_OFFS_WINDOW)
                        nxt_cal_dac = cal_dac_ff - 8'h01;
                    else if ($signed(adc_offset_i) < -`RGFC_OFFS_WINDOW)
                        nxt_cal_dac = cal_dac_ff + 8'h01;
                    else
                        nxt_state = ST_IDLE;
                    nxt_steps = steps_ff + 8'h01;
                    if (steps_ff == `RGFC_SERVO_MAX_STEPS)
                        nxt_state = ST_IDLE;
                end
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // request flag is loaded high by reset for the power-up run;
    // a host request during a run is kept for one more run
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff   <= ST_IDLE;
            cal_dac_ff <= `RGFC_CAL_DAC_RST;
            steps_ff   <= 8'h00;
            cal_req_ff <= 1'b1;
        end
        else
        begin
            state_ff   <= nxt_state;
            cal_dac_ff <= nxt_cal_dac;
            steps_ff   <= nxt_steps;
            if (wr_offs && reg_wdata_i[`RGFC_OFFS_START_BIT])
                cal_req_ff <= 1'b1;
            else if (state_ff == ST_IDLE)
                cal_req_ff <= 1'b0;
        end
    end

    // =============================================================
    // gain code capture; held while the servo runs
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gain_idx_ff <= 6'h00;
            pend_idx_ff <= 6'h00;
            pend_ff     <= 1'b0;
        end
        else if (cal_on && !cal_done)
        begin
            if (gain_load_i)
            begin
                pend_idx_ff <= gain_to_idx(gain_code_i, gain_mode3_i);
                pend_ff     <= 1'b1;
            end
        end
        else if (gain_load_i)
        begin
            gain_idx_ff <= gain_to_idx(gain_code_i, gain_mode3_i);
            pend_ff     <= 1'b0;
        end
        else if (pend_ff)
        begin
            gain_idx_ff <= pend_idx_ff;
            pend_ff     <= 1'b0;
        end
    end

    rgfc_gain_lut u_lut
    (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .gain_idx_i (gain_idx_ff),
        .coarse_o   (lut_coarse),
        .fine_o     (lut_fine)
    );

    // =============================================================
    // stage drive; calibration overrides the table
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            coarse_ff <= 4'h0;
            fine_ff   <= 3'h0;
            short_ff  <= 1'b0;
        end
        else
        begin
            short_ff  <= cal_on;
            coarse_ff <= cal_on ? `RGFC_COARSE_MAX : lut_coarse;
            fine_ff   <= cal_on ? `RGFC_FINE_MAX : lut_fine;
        end
    end

    assign reg_rdata_o         = rdata_ff;
    assign coarse_gain_stage_o = coarse_ff;
    assign fine_gain_stage_o   = fine_ff;
    assign input_short_o       = short_ff;
    assign cal_dac_o           = cal_dac_ff;
    assign offset_cal_busy_o   = state_ff[1];
    assign filter_enable_o     = filt_ctrl_ff[`RGFC_FILT_EN_BIT];
    assign filter_target_o     = filt_target_ff;
    assign filter_cal_busy_o   = fcal_busy_ff;

endmodule // rgfc_top

// >>> verification/rgfc_asserts.sv
`timescale 1ns/100ps
// =============================================
// port checker for the receive gain and filter control
module rgfc_asserts
(
    input wire        mclk_i,
    input wire        rst_i,
    input wire        reg_wr_i,
    input wire [7:0]  reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        adc_valid_i,
    input wire [9:0]  adc_offset_i,
    input wire [3:0]  coarse_gain_stage_o,
    input wire [2:0]  fine_gain_stage_o,
    input wire        input_short_o,
    input wire [7:0]  cal_dac_o,
    input wire        offset_cal_busy_o,
    input wire        filter_enable_o,
    input wire [7:0]  filter_target_o,
    input wire        filter_cal_busy_o
);
    reg [11:0] fcal_cnt_ff;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // busy cycles since the last target write; a rewrite restarts the count
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            fcal_cnt_ff <= 12'h000;
        else if (reg_wr_i && reg_addr_i == 8'h08)
            fcal_cnt_ff <= 12'h000;
        else if (filter_cal_busy_o)
            fcal_cnt_ff <= fcal_cnt_ff + 12'h001;
    end
    sequence s_tgt_wr;
        reg_wr_i && reg_addr_i == 8'h08;
    endsequence
    sequence s_cal_req;
        reg_wr_i && reg_addr_i == 8'h09 && reg_wdata_i[0] && !offset_cal_busy_o;
    endsequence
    sequence s_busy_on;
        ##1 offset_cal_busy_o;
    endsequence
    a_short_follows_busy: assert property ($rose(offset_cal_busy_o) |=> input_short_o)
        else $error("short not raised after busy");
    a_forced_high_gain: assert property (offset_cal_busy_o && input_short_o |->
        coarse_gain_stage_o == 4'h9 && fine_gain_stage_o == 3'h6)
        else $error("gain not forced during offset cal");
    a_servo_step_down: assert property (offset_cal_busy_o && adc_valid_i &&
        $signed(adc_offset_i) > 32 |=> cal_dac_o == $past(cal_dac_o) - 8'h01)
        else $error("dac did not step down");
    a_servo_step_up: assert property (offset_cal_busy_o && adc_valid_i &&
        $signed(adc_offset_i) < -32 |=> cal_dac_o == $past(cal_dac_o) + 8'h01)
        else $error("dac did not step up");
    a_servo_done: assert property (offset_cal_busy_o && adc_valid_i &&
        $signed(adc_offset_i) <= 32 && $signed(adc_offset_i) >= -32 |=> !offset_cal_busy_o)
        else $error("servo kept running inside window");
    a_cal_request: assert property (s_cal_req |=> s_busy_on)
        else $error("host request did not start offset cal");
    a_target_write: assert property (s_tgt_wr |=>
        filter_cal_busy_o && filter_target_o == $past(reg_wdata_i))
        else $error("target write not taken");
    a_fcal_length: assert property ($fell(filter_cal_busy_o) |-> fcal_cnt_ff == 12'h9C3)
        else $error("filter cal length wrong");
    a_filter_enable: assert property (reg_wr_i && reg_addr_i == 8'h07 |=>
        filter_enable_o == $past(reg_wdata_i[0]))
        else $error("filter enable not written");
endmodule // rgfc_asserts

// >>> verification/rgfc_backend_model.sv
`timescale 1ns/100ps
// =============================================
// back end model: turns the cal dac code into a measured offset
module rgfc_backend_model
#(
    parameter GAP = 3
)
(
    input  wire       mclk_i,
    input  wire [7:0] cal_dac_i,
    input  wire [7:0] zero_i,
    output reg        adc_valid_o = 1'b0,
    output reg  [9:0] adc_offset_o = 10'h000
);
    integer   cnt = 0;
    reg [9:0] meas;
    // 4 codes of offset per dac step from zero_i; between samples the lines
    // show the inverse so a stale value is never mistaken for a fresh one
    always @(negedge mclk_i)
    begin
        meas = ({2'b00, cal_dac_i} - {2'b00, zero_i}) << 2;
        cnt = (cnt >= GAP) ? 0 : cnt + 1;
        adc_valid_o <= (cnt == 0);
        adc_offset_o <= (cnt == 0) ? meas : ~meas;
    end
endmodule // rgfc_backend_model

// >>> verification/rgfc_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks = total_checks + 1; if ((a) !== (e)) begin \
    failures = failures + 1; $display("[ERR] %0t value %h", $time, (a)); end end
// =============================================
// bench for the receive gain and filter control
module rgfc_top_tb;
    reg        mclk_i = 1'b0;
    reg        rst_i = 1'b1;
    reg        reg_wr_i = 1'b0;
    reg        reg_rd_i = 1'b0;
    reg        gain_load_i = 1'b0;
    reg        gain_mode3_i = 1'b0;
    reg  [5:0] gain_code_i = 6'h00;
    reg  [7:0] reg_addr_i = 8'h00;
    reg  [7:0] reg_wdata_i = 8'h00;
    reg  [7:0] zero = 8'h70;
    reg  [7:0] rd_d;
    wire       adc_valid_i;
    wire [9:0] adc_offset_i;
    wire [7:0] reg_rdata_o, cal_dac_o, filter_target_o;
    wire [3:0] coarse_gain_stage_o;
    wire [2:0] fine_gain_stage_o;
    wire       input_short_o, offset_cal_busy_o, filter_enable_o, filter_cal_busy_o;
    wire [6:0] gain_o = {coarse_gain_stage_o, fine_gain_stage_o};
    integer    failures = 0, total_checks = 0, seed = 32'hf88fd308, n, k;

    rgfc_top i_rgfc_top (.*);
    rgfc_backend_model i_rgfc_backend_model (.mclk_i(mclk_i), .cal_dac_i(cal_dac_o),
        .zero_i(zero), .adc_valid_o(adc_valid_i), .adc_offset_o(adc_offset_i));
    always #20 mclk_i = ~mclk_i;

    // gain index is dB plus 12; coarse takes 6 dB steps, fine the rest
    function [6:0] exp_gain(input [5:0] c, input m);
        integer idx, co;
        begin
            idx = m ? ((c[2:0] == 3'h7) ? 6 : c[2:0]) * 8 : ((c > 60) ? 60 : c);
            co = (idx > 54) ? 9 : idx / 6;
            exp_gain = co * 8 + idx - 6 * co;
        end
    endfunction
    task give_verdict;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // one strobe from falling edge to falling edge, read data a cycle later
    task bus(input rd, input [7:0] a, input [7:0] d);
        begin
            @(negedge mclk_i);
            {reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i} = {rd, !rd, a, d};
            @(negedge mclk_i);
            {reg_rd_i, reg_wr_i} = 2'b00;
            @(negedge mclk_i);
            rd_d = reg_rdata_o;
        end
    endtask
    // load a gain code and wait out the three stage pipeline
    task ld(input [5:0] c, input m);
        begin
            @(negedge mclk_i);
            {gain_load_i, gain_code_i, gain_mode3_i} = {1'b1, c, m};
            @(negedge mclk_i);
            gain_load_i = 1'b0;
            repeat (3) @(negedge mclk_i);
        end
    endtask
    // bounded wait for a busy flag to drop; a hang ends the run
    task wt(input off);
        begin
            n = 0;
            while (n < 6000 && (off ? offset_cal_busy_o : filter_cal_busy_o) !== 1'b0)
            begin
                @(negedge mclk_i);
                n = n + 1;
            end
            if (n == 6000)
            begin
                failures = failures + 1;
                give_verdict;
            end
        end
    endtask

    initial
    begin
        repeat (2) @(negedge mclk_i);
        rst_i = 1'b0;
        bus(1'b1, 8'h07, 8'h00); `CHK(rd_d, 8'h01)
        bus(1'b1, 8'h08, 8'h00); `CHK(rd_d, 8'h80)
        `CHK({input_short_o, gain_o}, 8'hCE)
        wt(1'b1); `CHK(cal_dac_o, 8'h78)
        $display("test power-up cal done");
        for (k = 0; k < 24; k = k + 1)
        begin
            ld((k < 4) ? {6{k[0]}} : $random(seed), (k < 4) ? k[1] : $random(seed));
            `CHK(gain_o, exp_gain(gain_code_i, gain_mode3_i))
        end
        $display("test gain table done");
        zero = 8'h90;
        bus(1'b0, 8'h09, 8'h01);
        ld(6'h14, 1'b0); `CHK(gain_o, 7'h4E)
        bus(1'b1, 8'h09, 8'h00); `CHK(rd_d, 8'h02)
        wt(1'b1); `CHK(cal_dac_o, 8'h88)
        repeat (4) @(negedge mclk_i);
        `CHK(gain_o, exp_gain(6'h14, 1'b0))
        $display("test host cal done");
        bus(1'b0, 8'h07, 8'h00); `CHK(filter_enable_o, 1'b0)
        bus(1'b1, 8'h20, 8'h00); `CHK(rd_d, 8'h00)
        k = $random(seed);
        bus(1'b0, 8'h08, k[7:0]); `CHK(filter_target_o, k[7:0])
        wt(1'b0); `CHK(n + 1, 2499)
        bus(1'b0, 8'h08, k[7:0]); `CHK(filter_cal_busy_o, 1'b1)
        bus(1'b1, 8'h09, 8'h00); `CHK(rd_d, 8'h04)
        // the status read used three of the busy cycles before the wait
        wt(1'b0); `CHK(n + 4, 2499)
        $display("test filter done");
        give_verdict;
    end
endmodule // rgfc_top_tb

bind rgfc_top rgfc_asserts i_rgfc_asserts (.*);
